/* logic/ctap_top.sv */
// Purpose : test register access into a two way 8k byte cache array
// Assumes : classic wishbone slave, one clock, synchronous reset
// Notes   : also takes read allocations from the processor side
`timescale 1ns/1ps
module ctap_top
   import ctap_pkg::*;
(
   // clock and reset
   input  wire logic               mclk_in,
   input  wire logic               rst_in,
   // cache flush pin, active low, asynchronous
   input  wire logic               flush_n_in,
   // processor read allocation
   input  wire logic               alloc_in,
   input  wire logic [7:0]         alloc_set_in,
   input  wire logic [1:0]         alloc_line_in,
   input  wire logic [19:0]        alloc_tag_in,
   input  wire logic [31:0]        alloc_data_in,
   output logic                    alloc_way_out,
   // wishbone slave
   input  wire logic               wb_cyc_in,
   input  wire logic               wb_stb_in,
   input  wire logic               wb_we_in,
   input  wire logic [3:0]         wb_adr_in,
   input  wire logic [3:0]         wb_sel_in,
   input  wire logic [31:0]        wb_dat_in,
   output logic [31:0]             wb_dat_out,
   output logic                    wb_ack_out
);
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [31:0]            data_mem [CTAP_WAYS][CTAP_LINES];
   logic [3:0]             vld_mem  [CTAP_WAYS][CTAP_LINES];
   logic [CTAP_TAG_W-1:0]  tag_mem  [CTAP_WAYS][CTAP_SETS];
   logic [CTAP_SETS-1:0]   blk_vld_r [CTAP_WAYS];
   logic [CTAP_SETS-1:0]   lru_r;
   logic [CTAP_SETS-1:0]   lru_known_r;

   logic [31:0]            data_r;
   logic [31:0]            tag_stat_r;
   logic [31:0]            cmd_r;
   logic                   op_pend_r;
   logic                   flush_m_r;
   logic                   flush_s_r;

   // ------------------------------------------------------------
   // flush pin synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      flush_m_r <= ~flush_n_in;
      flush_s_r <= flush_m_r;
   end

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   logic                   t_way;
   logic [CTAP_SET_W-1:0]  t_set;
   logic [CTAP_IDX_W-1:0]  t_idx;
   ctap_op_e               t_op;
   assign t_way = cmd_r[CTAP_CMD_WAY];
   assign t_set = cmd_r[CTAP_CMD_SET_HI:CTAP_CMD_SET_LO];
   // four lines of a set sit next to each other, so the block is 16 bytes
   assign t_idx = {t_set, cmd_r[CTAP_CMD_LN_HI:CTAP_CMD_LN_LO]};
   assign t_op  = ctap_op_e'(cmd_r[CTAP_CMD_OP_HI:CTAP_CMD_OP_LO]);

   // ------------------------------------------------------------
   // wishbone access
   // ------------------------------------------------------------
   logic acc;
   logic wr_acc;
   assign acc    = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~op_pend_r;
   assign wr_acc = acc & wb_we_in;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ack one cycle after the request; read data loads on reads only so that
   // the last read value stands across writes
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= CTAP_ZERO32;
      end else begin
         wb_ack_out <= acc;
         if (acc && !wb_we_in) begin
            unique case (wb_adr_in)
               CTAP_OFF_DATA: wb_dat_out <= data_r;
               CTAP_OFF_TAG:  wb_dat_out <= tag_stat_r;
               CTAP_OFF_CMD:  wb_dat_out <= cmd_r;
               default:       wb_dat_out <= CTAP_ZERO32;  // unmapped reads zero
            endcase
         end
      end
   end

   // command register; a nonzero op code arms one test operation
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         cmd_r     <= CTAP_ZERO32;
         op_pend_r <= 1'b0;
      end else if (wr_acc && wb_adr_in == CTAP_OFF_CMD) begin
         cmd_r     <= merge(cmd_r, wb_dat_in, wb_sel_in);
         op_pend_r <= wb_sel_in[0] & (wb_dat_in[CTAP_CMD_OP_HI:CTAP_CMD_OP_LO] != 2'b00);
      end else begin
         op_pend_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // data and tag/status registers, loaded by bus or by test read
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         data_r     <= CTAP_ZERO32;
         tag_stat_r <= CTAP_ZERO32;
      end else if (op_pend_r && t_op == CTAP_OP_READ) begin
         data_r <= data_mem[t_way][t_idx];
         tag_stat_r <= CTAP_ZERO32;
         tag_stat_r[CTAP_TS_TAG_HI:CTAP_TS_TAG_LO] <= tag_mem[t_way][t_set];
         tag_stat_r[CTAP_TS_LRU] <= lru_r[t_set];
         tag_stat_r[CTAP_TS_VLD_HI:CTAP_TS_VLD_LO] <= vld_mem[t_way][t_idx];
         tag_stat_r[CTAP_TS_BV] <= blk_vld_r[t_way][t_set];
      end else if (wr_acc) begin
         if (wb_adr_in == CTAP_OFF_DATA) begin
            data_r <= merge(data_r, wb_dat_in, wb_sel_in);
         end
         if (wb_adr_in == CTAP_OFF_TAG) begin
            // unused bits 11..8 and 1..0 stay zero
            tag_stat_r <= merge(tag_stat_r, wb_dat_in, wb_sel_in) & 32'hffff_f0fc;
         end
      end
   end

   // ------------------------------------------------------------
   // array writes: allocation, then test write which takes priority
   // ------------------------------------------------------------
   logic [3:0] ts_vld;
   logic       alloc_way;
   assign ts_vld    = tag_stat_r[CTAP_TS_VLD_HI:CTAP_TS_VLD_LO];
   // unknown lru forces way 1, otherwise the less recent way
   assign alloc_way = lru_known_r[alloc_set_in] ? ~lru_r[alloc_set_in] : 1'b1;

   always_ff @(posedge mclk_in) begin
      if (alloc_in) begin
         tag_mem[alloc_way][alloc_set_in] <= alloc_tag_in;
         data_mem[alloc_way][{alloc_set_in, alloc_line_in}] <= alloc_data_in;
      end
      if (op_pend_r && t_op == CTAP_OP_WRITE) begin
         tag_mem[t_way][t_set] <= tag_stat_r[CTAP_TS_TAG_HI:CTAP_TS_TAG_LO];
         // only bytes marked valid take the data; hence valids must come first
         for (int b = 0; b < 4; b++) begin
            if (ts_vld[b]) begin
               data_mem[t_way][t_idx][b*8 +: 8] <= data_r[b*8 +: 8];
            end
         end
      end
   end

   // byte valids are not reset; test reads return them as stored, whatever the block valid bit
   always_ff @(posedge mclk_in) begin
      if (alloc_in) begin
         for (int l = 0; l < 4; l++) begin
            vld_mem[alloc_way][{alloc_set_in, 2'(l)}] <= 4'h0;
         end
         vld_mem[alloc_way][{alloc_set_in, alloc_line_in}] <= 4'hf;
      end
      if (op_pend_r && t_op == CTAP_OP_WRITE) begin
         vld_mem[t_way][t_idx] <= ts_vld;
      end
   end

   // block valid bits, cleared by reset, flush and invalidate
   always_ff @(posedge mclk_in) begin
      if (rst_in || flush_s_r) begin
         for (int w = 0; w < CTAP_WAYS; w++) begin
            blk_vld_r[w] <= '0;
         end
      end else begin
         if (alloc_in) begin
            blk_vld_r[alloc_way][alloc_set_in] <= 1'b1;
         end
         if (op_pend_r && t_op == CTAP_OP_WRITE) begin
            blk_vld_r[t_way][t_set] <= tag_stat_r[CTAP_TS_BV];
         end
         if (op_pend_r && t_op == CTAP_OP_INVAL) begin
            blk_vld_r[t_way][t_set] <= 1'b0;
         end
      end
   end

   // lru tracking; test writes leave it alone
   always_ff @(posedge mclk_in) begin
      if (rst_in || flush_s_r) begin
         lru_known_r <= '0;
         lru_r       <= '0;
      end else if (alloc_in) begin
         lru_known_r[alloc_set_in] <= 1'b1;
         lru_r[alloc_set_in]       <= alloc_way;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         alloc_way_out <= 1'b0;
      end else if (alloc_in) begin
         alloc_way_out <= alloc_way;
      end
   end
endmodule

/* logic/ctap_pkg.sv */
// Purpose : constants for the cache test access block
// Assumes : 32-bit classic wishbone register bus, word aligned
// Notes   : register offsets are byte addresses
package ctap_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [3:0] CTAP_OFF_DATA = 4'h0;
   localparam logic [3:0] CTAP_OFF_TAG  = 4'h4;
   localparam logic [3:0] CTAP_OFF_CMD  = 4'h8;

   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int CTAP_WAYS     = 2;
   localparam int CTAP_SETS     = 256;
   localparam int CTAP_LINES    = 1024;   // per way, four bytes each
   localparam int CTAP_TAG_W    = 20;
   localparam int CTAP_SET_W    = 8;
   localparam int CTAP_LSEL_W   = 2;
   localparam int CTAP_IDX_W    = 10;

   // ------------------------------------------------------------
   // tag/status fields
   // ------------------------------------------------------------
   localparam int CTAP_TS_TAG_LO = 12;
   localparam int CTAP_TS_TAG_HI = 31;
   localparam int CTAP_TS_LRU    = 7;
   localparam int CTAP_TS_VLD_LO = 3;
   localparam int CTAP_TS_VLD_HI = 6;
   localparam int CTAP_TS_BV     = 2;

   // ------------------------------------------------------------
   // command fields
   // ------------------------------------------------------------
   localparam int CTAP_CMD_WAY    = 12;
   localparam int CTAP_CMD_SET_LO = 4;
   localparam int CTAP_CMD_SET_HI = 11;
   localparam int CTAP_CMD_LN_LO  = 2;
   localparam int CTAP_CMD_LN_HI  = 3;
   localparam int CTAP_CMD_OP_LO  = 0;
   localparam int CTAP_CMD_OP_HI  = 1;

   typedef enum logic [1:0] {
      CTAP_OP_NONE  = 2'b00,
      CTAP_OP_WRITE = 2'b01,
      CTAP_OP_READ  = 2'b10,
      CTAP_OP_INVAL = 2'b11
   } ctap_op_e;

   localparam logic [31:0] CTAP_ZERO32 = 32'h0000_0000;
endpackage

/* bench/ctap_chk.sv */
// Purpose: port level checks for ctap_top
// Assumes: one clock, synchronous active high reset
// Notes  : per-set lru is invisible here, only the first allocation is tracked
`timescale 1ns/1ps
module ctap_chk (
   // clock, reset, flush
   input wire logic        mclk_in,
   input wire logic        rst_in,
   input wire logic        flush_n_in,
   // allocation
   input wire logic        alloc_in,
   input wire logic        alloc_way_out,
   // register bus
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic [3:0]  wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic        wb_ack_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   logic seen_r;
   // cleared at once on flush; bench keeps allocations clear of the sync lag
   always_ff @(posedge mclk_in) begin
      if (rst_in || !flush_n_in) seen_r <= 1'b0;
      else if (alloc_in) seen_r <= 1'b1;
   end
   sequence s_req; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
   sequence s_ans; wb_ack_out ##1 !wb_ack_out; endsequence
   ack_answer_a: assert property (s_req |-> ##[1:2] s_ans) else $error("no ack");
   ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
      else $error("stray ack");
   reset_quiet_a: assert property (@(posedge mclk_in) disable iff (1'b0) rst_in |=>
      !wb_ack_out && wb_dat_out == 32'h0 && !alloc_way_out) else $error("reset state");
   first_alloc_a: assert property (alloc_in && !seen_r |=> alloc_way_out)
      else $error("first way");
   way_hold_a: assert property (!alloc_in |=> $stable(alloc_way_out))
      else $error("way moved");
   dout_hold_a: assert property ($changed(wb_dat_out) |-> wb_ack_out && !$past(wb_we_in))
      else $error("dout moved");
   unmapped_zero_a: assert property (s_req and (!wb_we_in && wb_adr_in == 4'hc) |->
      ##[1:2] (wb_ack_out && wb_dat_out == 32'h0)) else $error("unmapped data");
   ack_gap_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("long ack");
endmodule
bind ctap_top ctap_chk u_chk (.mclk_in(mclk_in), .rst_in(rst_in), .flush_n_in(flush_n_in),
   .alloc_in(alloc_in), .alloc_way_out(alloc_way_out), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));

/* bench/test_ctap_top.sv */
// Purpose: directed bench for ctap_top
// Assumes: command op runs one edge after its write is acked
// Notes  : only entries written or allocated first are read back
`timescale 1ns/1ps
module test_ctap_top;
   import ctap_pkg::*;
   logic        mclk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        flush_n_in = 1'b1;
   logic        alloc_in = 1'b0;
   logic [7:0]  alloc_set_in = 8'h00;
   logic [1:0]  alloc_line_in = 2'h0;
   logic [19:0] alloc_tag_in = 20'h00000;
   logic [31:0] alloc_data_in = 32'h0;
   logic        alloc_way_out;
   logic        wb_cyc_in = 1'b0;
   logic        wb_stb_in = 1'b0;
   logic        wb_we_in = 1'b0;
   logic [3:0]  wb_adr_in = 4'h0;
   logic [3:0]  wb_sel_in = 4'h0;
   logic [31:0] wb_dat_in = 32'h0;
   logic [31:0] wb_dat_out;
   logic        wb_ack_out;
   logic [31:0] rdat;
   int          fails = 0;
   int          n_compared = 0;
   always #2.5 mclk_in = ~mclk_in;
   ctap_top uut (.mclk_in(mclk_in), .rst_in(rst_in), .flush_n_in(flush_n_in),
      .alloc_in(alloc_in), .alloc_set_in(alloc_set_in), .alloc_line_in(alloc_line_in),
      .alloc_tag_in(alloc_tag_in), .alloc_data_in(alloc_data_in),
      .alloc_way_out(alloc_way_out), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
      .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
      .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one classic cycle; ack is read before this edge's updates land
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int i;
      @(posedge mclk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= a;
      wb_dat_in <= d;
      wb_sel_in <= s;
      for (i = 0; i < 20 && wb_ack_out !== 1'b1; i++) @(posedge mclk_in);
      if (i == 20) begin
         fails++;
         test_done();
      end
      rdat = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hf);
      chk(rdat, exp);
   endtask
   task automatic op(input logic w, input logic [7:0] s, input logic [1:0] l, input ctap_op_e o);
      wr(CTAP_OFF_CMD, {19'h0, w, s, l, o});
   endtask
   task automatic alloc(input logic [19:0] t, input logic [31:0] d);
      @(posedge mclk_in);
      alloc_in <= 1'b1;
      alloc_set_in <= 8'h40;
      alloc_tag_in <= t;
      alloc_data_in <= d;
      @(posedge mclk_in);
      alloc_in <= 1'b0;
      @(posedge mclk_in);
   endtask
   task automatic t_reset;
      rdchk(CTAP_OFF_DATA, 32'h0);
      rdchk(CTAP_OFF_CMD, 32'h0);
      chk({31'h0, alloc_way_out}, 32'h0);
      $display("t_reset done");
   endtask
   task automatic t_wr_rd;
      wr(CTAP_OFF_DATA, 32'ha5a5_5a5a);
      wr(CTAP_OFF_TAG, 32'habcd_e0fc);
      op(1'b1, 8'hff, 2'h3, CTAP_OP_WRITE);
      wr(CTAP_OFF_DATA, 32'h0);
      wr(CTAP_OFF_TAG, 32'h0);
      op(1'b1, 8'hff, 2'h3, CTAP_OP_READ);
      rdchk(CTAP_OFF_DATA, 32'ha5a5_5a5a);
      rdchk(CTAP_OFF_TAG, 32'habcd_e07c);
      $display("t_wr_rd done");
   endtask
   // second write names only bytes 0 and 2 as valid
   task automatic t_partial;
      wr(CTAP_OFF_DATA, 32'h1122_3344);
      wr(CTAP_OFF_TAG, 32'h1357_907c);
      op(1'b0, 8'hff, 2'h3, CTAP_OP_WRITE);
      wr(CTAP_OFF_DATA, 32'haabb_ccdd);
      wr(CTAP_OFF_TAG, 32'h1357_902c);
      op(1'b0, 8'hff, 2'h3, CTAP_OP_WRITE);
      op(1'b0, 8'hff, 2'h3, CTAP_OP_READ);
      rdchk(CTAP_OFF_DATA, 32'h11bb_33dd);
      rdchk(CTAP_OFF_TAG, 32'h1357_902c);
      op(1'b1, 8'hff, 2'h3, CTAP_OP_READ);
      rdchk(CTAP_OFF_DATA, 32'ha5a5_5a5a);
      $display("t_partial done");
   endtask
   task automatic t_inval;
      op(1'b1, 8'hff, 2'h3, CTAP_OP_INVAL);
      op(1'b1, 8'hff, 2'h3, CTAP_OP_READ);
      rdchk(CTAP_OFF_TAG, 32'habcd_e078);
      op(1'b0, 8'hff, 2'h3, CTAP_OP_READ);
      rdchk(CTAP_OFF_TAG, 32'h1357_902c);
      $display("t_inval done");
   endtask
   task automatic t_alloc;
      alloc(20'h12345, 32'hdead_beef);
      chk({31'h0, alloc_way_out}, 32'h1);
      op(1'b1, 8'h40, 2'h0, CTAP_OP_READ);
      rdchk(CTAP_OFF_DATA, 32'hdead_beef);
      rdchk(CTAP_OFF_TAG, 32'h1234_50fc);
      alloc(20'h54321, 32'h0bad_f00d);
      chk({31'h0, alloc_way_out}, 32'h0);
      op(1'b0, 8'h40, 2'h0, CTAP_OP_READ);
      rdchk(CTAP_OFF_TAG, 32'h5432_107c);
      $display("t_alloc done");
   endtask
   task automatic t_flush;
      @(posedge mclk_in);
      flush_n_in <= 1'b0;
      repeat (4) @(posedge mclk_in);
      flush_n_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
      op(1'b0, 8'h40, 2'h0, CTAP_OP_READ);
      rdchk(CTAP_OFF_TAG, 32'h5432_1078);
      alloc(20'h0f0f0, 32'h0);
      chk({31'h0, alloc_way_out}, 32'h1);
      $display("t_flush done");
   endtask
   // reserved tag bits, byte lanes, unmapped place, idle op code
   task automatic t_misc;
      wr(CTAP_OFF_TAG, 32'hffff_ffff);
      rdchk(CTAP_OFF_TAG, 32'hffff_f0fc);
      wr(4'hc, 32'hffff_ffff);
      rdchk(4'hc, 32'h0);
      wr(CTAP_OFF_DATA, 32'hffff_ffff);
      bus(1'b1, CTAP_OFF_DATA, 32'h0, 4'b0010);
      op(1'b0, 8'h40, 2'h0, CTAP_OP_NONE);
      rdchk(CTAP_OFF_DATA, 32'hffff_00ff);
      $display("t_misc done");
   endtask
   initial begin
      repeat (12) @(posedge mclk_in);
      rst_in <= 1'b0;
      t_reset();
      t_wr_rd();
      t_partial();
      t_inval();
      t_alloc();
      t_flush();
      t_misc();
      test_done();
   end
endmodule
